// File: hw/pwm_timer_pkg.sv
// Package: register map, field positions, reset values and types of the dual timer
package pwm_timer_pkg;
    // ************************************************************
    // Register byte addresses (one aligned word each)
    // ************************************************************
    localparam logic [7:0] CTRL_ONE_0    = 8'h00;
    localparam logic [7:0] CTRL_TWO_0    = 8'h04;
    localparam logic [7:0] CMP_HI_0      = 8'h08;
    localparam logic [7:0] CMP_LO_0      = 8'h0C;
    localparam logic [7:0] LIM_HI_0      = 8'h10;
    localparam logic [7:0] LIM_LO_0      = 8'h14;
    localparam logic [7:0] COUNT_0       = 8'h18;
    localparam logic [7:0] CAPT_0        = 8'h1C;
    localparam logic [7:0] STATUS_0      = 8'h20;
    localparam logic [7:0] UNIT_STRIDE   = 8'h40;
    localparam logic [7:0] SHARED_THREE  = 8'h80;
    localparam logic [7:0] POLARITY_CFG  = 8'h84;
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CLR_BIT  = 0;
    localparam int CLRM_BIT = 1;
    localparam int RUN_BIT  = 2;
    localparam int RUNM_BIT = 3;
    localparam int MODE_BIT = 7;
    localparam int WAV_BIT  = 5;
    localparam int S_RUN    = 0;
    localparam int S_SET    = 1;
    localparam int S_OUT    = 2;
    localparam int S_OVF    = 3;
    localparam int M1_BIT   = 5;
    localparam int CKS_BIT  = 4;
    localparam int M0_BIT   = 7;
    localparam int RPOL_BIT = 3;
    localparam int CPOL_BIT = 4;
    // ************************************************************
    // Reset values and limits
    // ************************************************************
    localparam logic [15:0] LIMIT_RST = 16'hFFFF;
    localparam logic [4:0]  PRESC_MAX = 5'h10;
    localparam logic [31:0] PSLVERR_NONE = 32'h0000_0000;

    typedef enum logic [2:0] {
        EDGE_IDLE = 3'b001,
        EDGE_RUN  = 3'b010,
        EDGE_DONE = 3'b100
    } edge_state_t;

    typedef struct packed {
        logic [7:0]  ctrl_one;
        logic [7:0]  ctrl_two;
        logic [7:0]  cmp_hi_buf;
        logic [7:0]  lim_hi_buf;
        logic [15:0] cmp_pend;
        logic        cmp_new;
        logic [15:0] cmp_act;
        logic [15:0] limit;
        logic [15:0] count;
        logic [15:0] capt;
        logic [15:0] presc;
        logic        ovf;
        logic        wave;
        logic        running;
        logic        run_prev;
        edge_state_t est;
    } unit_t;

    typedef struct packed {
        logic        out_r;
        logic        oe_r;
    } pin_t;
endpackage

// File: hw/dual_pwm_timer.sv
// Dual 16-bit timer / PWM unit with APB register slave
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
module dual_pwm_timer (
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        EXTERNAL_RUN_PIN,
    input  wire logic        EXTERNAL_CLEAR_PIN,
    input  wire logic        EXTERNAL_COUNT_CLOCK_PIN,
    output logic      [1:0]  UNIT_OUTPUT_WAVE,
    output logic      [1:0]  UNIT_OUTPUT_WAVE_OE
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        pwm_timer_pkg::unit_t [1:0] u;
        logic [7:0]  shared3;
        logic [7:0]  pol;
        logic [2:0]  run_s;
        logic [2:0]  clr_s;
        logic [2:0]  ck_s;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        pwm_timer_pkg::pin_t [1:0] pin;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic [1:0]  presc_tick;
    logic [1:0]  unit_set;
    logic [1:0]  count_en;
    logic [1:0]  phase_end;
    logic        ext_run_lvl;
    logic        ext_run_edge;
    logic        ext_clr_lvl;
    logic        ext_clr_edge;
    logic        ext_ck_en;
    logic        wr_acc;
    logic        rd_acc;
    logic [7:0]  local_addr;
    logic [1:0]  unit_hit;
    logic        shared_hit;

    // ************************************************************
    // External pins of unit 0
    // ************************************************************
    always_comb begin
        // Stage 1 feeds stage 2 only; detection looks at stages 2 and 3
        ext_run_lvl  = st_r.run_s[1] ^ st_r.pol[pwm_timer_pkg::RPOL_BIT];
        ext_run_edge = ext_run_lvl
                     & ~(st_r.run_s[2] ^ st_r.pol[pwm_timer_pkg::RPOL_BIT]);
        ext_clr_lvl  = st_r.clr_s[1] ^ st_r.pol[pwm_timer_pkg::CPOL_BIT];
        ext_clr_edge = ext_clr_lvl
                     & ~(st_r.clr_s[2] ^ st_r.pol[pwm_timer_pkg::CPOL_BIT]);
        ext_ck_en    = st_r.ck_s[1] & ~st_r.ck_s[2];
    end

    // ************************************************************
    // Per-unit combinational terms
    // ************************************************************
    for (genvar i = 0; i < 2; i++) begin : g_unit
        logic [4:0] exp_v;
        logic       src_en;
        logic       internal_set;
        logic       ext_clear;
        logic       mask;
        always_comb begin
            exp_v  = (st_r.u[i].ctrl_two[4:0] > pwm_timer_pkg::PRESC_MAX)
                   ? pwm_timer_pkg::PRESC_MAX : st_r.u[i].ctrl_two[4:0];
            src_en = (i == 0 && st_r.shared3[pwm_timer_pkg::CKS_BIT]) ? ext_ck_en : 1'b1;
            // Tick when all low exponent bits of the prescaler roll over
            presc_tick[i] = src_en
                && ((st_r.u[i].presc & ((17'h1_0000 >> (16 - exp_v)) - 17'h1))
                    == (16'hFFFF >> (16 - exp_v)) || exp_v == 5'h00);
            internal_set = st_r.u[i].ctrl_one[pwm_timer_pkg::CLR_BIT];
            ext_clear    = 1'b0;
            if (i == 0 && st_r.u[0].ctrl_one[pwm_timer_pkg::CLRM_BIT]) begin
                ext_clear = ext_clr_edge;
            end else if (i == 0) begin
                ext_clear = ext_clr_lvl;
            end
            if (i == 0) begin
                unique case (st_r.shared3[1:0])
                    2'b01:   internal_set = ~ext_clear;
                    2'b10:   internal_set = internal_set & ~ext_clear;
                    default: internal_set = internal_set;
                endcase
            end
            mask = (i == 0) ? st_r.shared3[pwm_timer_pkg::M0_BIT]
                            : st_r.shared3[pwm_timer_pkg::M1_BIT];
            unit_set[i]  = internal_set & ~mask;
            count_en[i]  = unit_set[i] && presc_tick[i]
                        && (st_r.u[i].ctrl_one[pwm_timer_pkg::MODE_BIT]
                            || st_r.u[i].running);
            phase_end[i] = st_r.u[i].ctrl_one[pwm_timer_pkg::MODE_BIT]
                         ? (st_r.u[i].count >= st_r.u[i].limit - 16'h0001)
                         : (st_r.u[i].count >= st_r.u[i].cmp_act - 16'h0001);
        end
    end

    // ************************************************************
    // APB decode
    // ************************************************************
    always_comb begin
        wr_acc     = PSEL & PENABLE & PWRITE & ~st_r.pready;
        rd_acc     = PSEL & PENABLE & ~PWRITE & ~st_r.pready;
        local_addr = {2'b00, PADDR[5:0]};
        unit_hit[0] = PADDR[7:6] == 2'b00;
        unit_hit[1] = PADDR[7:6] == 2'b01;
        shared_hit  = PADDR[7:6] == 2'b10;
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic run_req;
        logic wr_u;
        logic [15:0] wdat16;
        run_req = 1'b0;
        wr_u    = 1'b0;
        wdat16  = 16'h0000;
        st_nxt  = st_r;
        st_nxt.run_s = {st_r.run_s[1:0], EXTERNAL_RUN_PIN};
        st_nxt.clr_s = {st_r.clr_s[1:0], EXTERNAL_CLEAR_PIN};
        st_nxt.ck_s  = {st_r.ck_s[1:0], EXTERNAL_COUNT_CLOCK_PIN};
        st_nxt.pready  = PSEL & PENABLE & ~st_r.pready;
        st_nxt.pslverr = 1'b0;

        for (int i = 0; i < 2; i++) begin
            // Run request from bit, pin level or pin edge
            run_req = st_r.u[i].ctrl_one[pwm_timer_pkg::RUN_BIT];
            if (i == 0 && st_r.shared3[3:2] != 2'b00) begin
                if (st_r.u[0].ctrl_one[pwm_timer_pkg::RUNM_BIT]) begin
                    unique case (st_r.u[0].est)
                        pwm_timer_pkg::EDGE_IDLE:
                            if (ext_run_edge) st_nxt.u[0].est = pwm_timer_pkg::EDGE_RUN;
                        pwm_timer_pkg::EDGE_RUN:
                            if (ext_run_edge) st_nxt.u[0].est = pwm_timer_pkg::EDGE_DONE;
                        pwm_timer_pkg::EDGE_DONE:
                            st_nxt.u[0].est = pwm_timer_pkg::EDGE_DONE;
                    endcase
                    run_req = (st_r.u[0].est == pwm_timer_pkg::EDGE_RUN)
                            && !(ext_run_edge);
                end else begin
                    run_req = ext_run_lvl;
                end
                if (st_r.shared3[3:2] == 2'b10) begin
                    run_req = run_req | st_r.u[0].ctrl_one[pwm_timer_pkg::RUN_BIT];
                end
            end
            st_nxt.u[i].running = run_req & unit_set[i]
                                & ~st_r.u[i].ctrl_one[pwm_timer_pkg::MODE_BIT];
            st_nxt.u[i].run_prev = st_r.u[i].running;

            if (!unit_set[i]) begin
                st_nxt.u[i].count   = 16'h0000;
                st_nxt.u[i].presc   = 16'h0000;
                st_nxt.u[i].ovf     = 1'b0;
                st_nxt.u[i].wave    = 1'b0;
                st_nxt.u[i].est     = pwm_timer_pkg::EDGE_IDLE;
                st_nxt.u[i].cmp_act = st_r.u[i].cmp_pend;
                st_nxt.u[i].cmp_new = 1'b0;
            end else begin
                // External source advances the prescaler only on its sampled edges
                if ((st_r.u[i].running | st_r.u[i].ctrl_one[pwm_timer_pkg::MODE_BIT])
                    && (i != 0 || !st_r.shared3[pwm_timer_pkg::CKS_BIT] || ext_ck_en))
                    st_nxt.u[i].presc = st_r.u[i].presc + 16'h0001;
                if (st_r.u[i].run_prev && !st_r.u[i].running
                    && !st_r.u[i].ctrl_one[pwm_timer_pkg::MODE_BIT]) begin
                    st_nxt.u[i].capt = st_r.u[i].count;
                end
                if (count_en[i]) begin
                    if (phase_end[i]) begin
                        st_nxt.u[i].count = 16'h0000;
                        st_nxt.u[i].ovf   = 1'b1;
                        if (st_r.u[i].cmp_new) begin
                            st_nxt.u[i].cmp_act = st_r.u[i].cmp_pend;
                            st_nxt.u[i].cmp_new = 1'b0;
                        end
                    end else begin
                        st_nxt.u[i].count = st_r.u[i].count + 16'h0001;
                    end
                end
                if (st_r.u[i].ctrl_one[pwm_timer_pkg::MODE_BIT]) begin
                    // PWM: high from period start until count meets compare
                    st_nxt.u[i].wave = (st_nxt.u[i].count < st_r.u[i].cmp_act)
                                    || (st_r.u[i].cmp_act >= st_r.u[i].limit);
                    if (st_r.u[i].cmp_act == 16'h0000) st_nxt.u[i].wave = 1'b0;
                end else if (count_en[i] && phase_end[i]) begin
                    st_nxt.u[i].wave = st_r.u[i].ctrl_two[pwm_timer_pkg::WAV_BIT]
                                     ? ~st_r.u[i].wave : 1'b1;
                end else if (!st_r.u[i].ctrl_two[pwm_timer_pkg::WAV_BIT] && count_en[i]) begin
                    st_nxt.u[i].wave = 1'b0;
                end
            end

            // Register writes
            wr_u   = wr_acc & unit_hit[i];
            wdat16 = 16'h0000;
            if (wr_u) begin
                unique case (local_addr)
                    pwm_timer_pkg::CTRL_ONE_0: st_nxt.u[i].ctrl_one = PWDATA[7:0];
                    pwm_timer_pkg::CTRL_TWO_0: begin
                        st_nxt.u[i].ctrl_two = PWDATA[7:0];
                        if (PWDATA[4:0] > pwm_timer_pkg::PRESC_MAX)
                            st_nxt.u[i].ctrl_two[4:0] = pwm_timer_pkg::PRESC_MAX;
                    end
                    pwm_timer_pkg::CMP_HI_0:   st_nxt.u[i].cmp_hi_buf = PWDATA[7:0];
                    pwm_timer_pkg::CMP_LO_0: begin
                        st_nxt.u[i].cmp_pend = {st_r.u[i].cmp_hi_buf, PWDATA[7:0]};
                        st_nxt.u[i].cmp_new  = 1'b1;
                    end
                    pwm_timer_pkg::LIM_HI_0:   st_nxt.u[i].lim_hi_buf = PWDATA[7:0];
                    pwm_timer_pkg::LIM_LO_0: begin
                        wdat16 = {st_r.u[i].lim_hi_buf, PWDATA[7:0]};
                        st_nxt.u[i].limit = wdat16;
                    end
                    default: st_nxt.pslverr = 1'b0;
                endcase
            end
            st_nxt.pin[i].out_r = st_nxt.u[i].wave;
            st_nxt.pin[i].oe_r  = unit_set[i];
        end

        if (wr_acc && shared_hit) begin
            if (PADDR == pwm_timer_pkg::SHARED_THREE) st_nxt.shared3 = PWDATA[7:0];
            if (PADDR == pwm_timer_pkg::POLARITY_CFG) st_nxt.pol = PWDATA[7:0];
        end

        if (rd_acc) begin
            st_nxt.prdata = 32'h0000_0000;
            for (int i = 0; i < 2; i++) begin
                if (unit_hit[i]) begin
                    unique case (local_addr)
                        pwm_timer_pkg::CTRL_ONE_0: st_nxt.prdata[7:0] = st_r.u[i].ctrl_one;
                        pwm_timer_pkg::CTRL_TWO_0: st_nxt.prdata[7:0] = st_r.u[i].ctrl_two;
                        pwm_timer_pkg::COUNT_0:    st_nxt.prdata[15:0] = st_r.u[i].count;
                        pwm_timer_pkg::CAPT_0:     st_nxt.prdata[15:0] = st_r.u[i].capt;
                        pwm_timer_pkg::STATUS_0:
                            st_nxt.prdata[3:0] = {st_r.u[i].ovf, st_r.u[i].wave,
                                                  unit_set[i], st_r.u[i].running};
                        default:                   st_nxt.prdata = 32'h0000_0000;
                    endcase
                end
            end
            if (PADDR == pwm_timer_pkg::SHARED_THREE) st_nxt.prdata[7:0] = st_r.shared3;
            if (PADDR == pwm_timer_pkg::POLARITY_CFG) st_nxt.prdata[7:0] = st_r.pol;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_r <= '0;
            st_r.u[0].limit <= pwm_timer_pkg::LIMIT_RST;
            st_r.u[1].limit <= pwm_timer_pkg::LIMIT_RST;
            st_r.u[0].est   <= pwm_timer_pkg::EDGE_IDLE;
            st_r.u[1].est   <= pwm_timer_pkg::EDGE_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_comb begin
        PRDATA  = st_r.prdata;
        PREADY  = st_r.pready;
        PSLVERR = st_r.pslverr;
        UNIT_OUTPUT_WAVE    = {st_r.pin[1].out_r, st_r.pin[0].out_r};
        UNIT_OUTPUT_WAVE_OE = {st_r.pin[1].oe_r, st_r.pin[0].oe_r};
    end
endmodule // dual_pwm_timer

// File: verif/dual_pwm_timer_properties.sv
// Port-level properties of the dual timer, bound to its top module
`timescale 1ns/100ps
module dual_pwm_timer_chk (
    input wire logic        CLK,
    input wire logic        RESETN,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic [1:0]  UNIT_OUTPUT_WAVE,
    input wire logic [1:0]  UNIT_OUTPUT_WAVE_OE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    logic rd;
    assign rd = PSEL && PENABLE && PREADY && !PWRITE;
    a_ready_one_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("ready late");
    a_ready_single: assert property (PREADY |=> !PREADY)
        else $error("ready too long");
    a_ready_cause: assert property (PREADY |-> PSEL && PENABLE)
        else $error("ready without access");
    a_oe_after_reset: assert property ($rose(RESETN) |-> UNIT_OUTPUT_WAVE_OE == 2'b00)
        else $error("pin driven at reset release");
    a_status_width: assert property (rd && PADDR == pwm_timer_pkg::STATUS_0
        |-> PRDATA[31:4] == 28'h0) else $error("status upper bits set");
    a_count_width: assert property (rd && PADDR == pwm_timer_pkg::COUNT_0
        |-> PRDATA[31:16] == 16'h0) else $error("count wider than 16 bits");
    a_presc_clamp: assert property (rd && PADDR == pwm_timer_pkg::CTRL_TWO_0
        |-> PRDATA[4:0] <= pwm_timer_pkg::PRESC_MAX) else $error("exponent above 16");
    a_set_drives_pin: assert property (rd && PADDR == pwm_timer_pkg::STATUS_0
        && $stable(UNIT_OUTPUT_WAVE_OE[0])
        |-> PRDATA[pwm_timer_pkg::S_SET] == UNIT_OUTPUT_WAVE_OE[0]) else $error("set vs enable");
    a_out_level: assert property (rd && PADDR == pwm_timer_pkg::STATUS_0
        && UNIT_OUTPUT_WAVE_OE[0] && $stable(UNIT_OUTPUT_WAVE[0])
        |-> PRDATA[pwm_timer_pkg::S_OUT] == UNIT_OUTPUT_WAVE[0]) else $error("status level");
    c_status_read: cover property (rd && PADDR == pwm_timer_pkg::STATUS_0);
    c_pwm_rise: cover property (UNIT_OUTPUT_WAVE_OE[0] && $rose(UNIT_OUTPUT_WAVE[0]));
    c_both_start: cover property ($rose(UNIT_OUTPUT_WAVE_OE == 2'b11));
endmodule // dual_pwm_timer_chk
bind dual_pwm_timer dual_pwm_timer_chk chk (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
    .UNIT_OUTPUT_WAVE(UNIT_OUTPUT_WAVE), .UNIT_OUTPUT_WAVE_OE(UNIT_OUTPUT_WAVE_OE));

// File: verif/ext_pins_model.sv
// External run, clear and count clock sources plus the loads on both outputs
`timescale 1ns/100ps
module ext_pins_model (
    input  wire logic       clk,
    input  wire logic       run_lvl,
    input  wire logic       clr_lvl,
    input  wire logic       cnt_en,
    input  wire logic [1:0] wave,
    input  wire logic [1:0] wave_oe,
    output logic            run_pin,
    output logic            clear_pin,
    output logic            count_clk_pin,
    output logic [1:0]      pin_level
);
    logic [1:0] div = 2'b00;
    initial {run_pin, clear_pin, count_clk_pin} = 3'b000;
    always @(posedge clk) begin
        run_pin <= run_lvl;
        clear_pin <= clr_lvl;
        div <= div + 2'b01;
        // Quarter of the master rate, still when not enabled
        count_clk_pin <= cnt_en & div[1];
    end
    // Floating outputs rest at the pull-up level
    assign pin_level[0] = wave_oe[0] ? wave[0] : 1'b1;
    assign pin_level[1] = wave_oe[1] ? wave[1] : 1'b1;
endmodule // ext_pins_model

// File: verif/tb_top.sv
// Self-checking bench of the dual timer
`timescale 1ns/100ps
module tb_top;
    typedef struct packed {
        logic [31:0] val;
        logic [31:0] msk;
    } note_t;
    logic        clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        run_pin;
    logic        clear_pin;
    logic        cnt_clk;
    logic [1:0]  wave;
    logic [1:0]  oe;
    logic [1:0]  level;
    logic        run_lvl;
    logic        clr_lvl;
    logic        cnt_en;
    logic [31:0] seed;
    int          fails;
    int          num_checks;
    note_t       exp_q[$];
    note_t       nt;
    dual_pwm_timer DUT (.CLK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(), .EXTERNAL_RUN_PIN(run_pin), .EXTERNAL_CLEAR_PIN(clear_pin),
        .EXTERNAL_COUNT_CLOCK_PIN(cnt_clk), .UNIT_OUTPUT_WAVE(wave), .UNIT_OUTPUT_WAVE_OE(oe));
    ext_pins_model ext (.clk(clk), .run_lvl(run_lvl), .clr_lvl(clr_lvl), .cnt_en(cnt_en),
        .wave(wave), .wave_oe(oe), .run_pin(run_pin), .clear_pin(clear_pin),
        .count_clk_pin(cnt_clk), .pin_level(level));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back('{e, m});
        apb(1'b0, a, 32'h0);
    endtask
    // Reads are compared in arrival order
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            nt = exp_q.pop_front();
            check(prdata & nt.msk, nt.val);
        end
    end
    task automatic prog(input logic [7:0] b, input logic [7:0] m, input int e, input int r,
                        input int c);
        wr(b + pwm_timer_pkg::CTRL_ONE_0, {24'h0, m});
        wr(b + pwm_timer_pkg::CTRL_TWO_0, 32'(e));
        wr(b + pwm_timer_pkg::LIM_HI_0, 32'(r >> 8));
        wr(b + pwm_timer_pkg::LIM_LO_0, 32'(r & 255));
        wr(b + pwm_timer_pkg::CMP_HI_0, 32'(c >> 8));
        wr(b + pwm_timer_pkg::CMP_LO_0, 32'(c & 255));
    endtask
    task automatic span(input int u, input logic v, output int c);
        c = 0;
        while (level[u] === v && c < 3000) begin
            @(posedge clk);
            c++;
        end
    endtask
    task automatic measure(input int u, output int hi, output int lo);
        int d;
        span(u, 1'b1, d);
        span(u, 1'b0, d);
        span(u, 1'b1, hi);
        span(u, 1'b0, lo);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #(100 * 60000);
        fails++;
        final_report();
    end
    initial begin
        int e, r, c, hi, lo, n;
        seed = 32'h25;
        {psel, penable, pwrite, run_lvl, clr_lvl, cnt_en, rst_n} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check({30'h0, oe}, 32'h0);
        rd(pwm_timer_pkg::STATUS_0, 32'h0, 32'hFFFFFFFF);
        rd(pwm_timer_pkg::COUNT_0, 32'h0, 32'hFFFFFFFF);
        wr(pwm_timer_pkg::CTRL_TWO_0, 32'h1F);
        rd(pwm_timer_pkg::CTRL_TWO_0, 32'h10, 32'h1F);
        for (int i = 0; i < 3; i++) begin
            e = xs() % 3;
            r = 3 + xs() % 14;
            c = 1 + xs() % (r - 1);
            prog(8'h00, 8'h80, e, r, c);
            wr(pwm_timer_pkg::CTRL_ONE_0, 32'h81);
            measure(0, hi, lo);
            check(32'(hi), 32'(c << e));
            check(32'(hi + lo), 32'(r << e));
            wr(pwm_timer_pkg::CMP_HI_0, 32'h01);
            measure(0, hi, lo);
            check(32'(hi), 32'(c << e));
            wr(pwm_timer_pkg::CTRL_ONE_0, 32'h80);
            repeat (2) @(posedge clk);
            check({31'h0, oe[0]}, 32'h0);
            rd(pwm_timer_pkg::COUNT_0, 32'h0, 32'hFFFF);
        end
        for (int k = 0; k < 2; k++) begin
            prog(8'h00, 8'h80, 0, 8, k * 8);
            wr(pwm_timer_pkg::CTRL_ONE_0, 32'h81);
            repeat (20) @(posedge clk);
            check({31'h0, level[0]}, 32'(k));
            span(0, level[0], n);
            check(32'(n), 32'd3000);
        end
        prog(8'h00, 8'h01, 1, 65535, 4);
        wr(pwm_timer_pkg::CTRL_ONE_0, 32'h05);
        measure(0, hi, lo);
        check(32'(hi), 32'd2);
        rd(pwm_timer_pkg::STATUS_0, 32'h3, 32'h3);
        wr(pwm_timer_pkg::CTRL_TWO_0, 32'h21);
        measure(0, hi, lo);
        check(32'(hi), 32'(lo));
        check(32'(hi), 32'd8);
        wr(pwm_timer_pkg::CTRL_ONE_0, 32'h01);
        rd(pwm_timer_pkg::STATUS_0, 32'h2, 32'h3);
        wr(pwm_timer_pkg::CTRL_ONE_0, 32'h00);
        rd(pwm_timer_pkg::STATUS_0, 32'h0, 32'hB);
        wr(pwm_timer_pkg::SHARED_THREE, 32'hA0);
        for (int u = 0; u < 2; u++) begin
            prog(8'(u * 64), 8'h80, 0, 6, 3);
            wr(8'(u * 64) + pwm_timer_pkg::CTRL_ONE_0, 32'h81);
        end
        check({30'h0, oe}, 32'h0);
        wr(pwm_timer_pkg::SHARED_THREE, 32'h00);
        n = 0;
        while (oe === 2'b00 && n < 20) begin
            @(posedge clk);
            n++;
        end
        check({30'h0, oe}, 32'h3);
        repeat (30) begin
            @(posedge clk);
            check({31'h0, level[0]}, {31'h0, level[1]});
        end
        prog(8'h00, 8'h01, 0, 65535, 16);
        wr(pwm_timer_pkg::SHARED_THREE, 32'h04);
        for (int k = 0; k < 4; k++) begin
            wr(pwm_timer_pkg::POLARITY_CFG, k[1] ? 32'h08 : 32'h00);
            run_lvl <= k[0];
            repeat (8) @(posedge clk);
            rd(pwm_timer_pkg::STATUS_0, {31'h0, k[0] ^ k[1]}, 32'h1);
        end
        run_lvl <= 1'b0;
        wr(pwm_timer_pkg::POLARITY_CFG, 32'h00);
        prog(8'h00, 8'h09, 0, 65535, 16);
        // Edge mode: rise starts, fall is ignored, next rise stops
        for (int k = 0; k < 3; k++) begin
            run_lvl <= ~k[0];
            repeat (8) @(posedge clk);
            rd(pwm_timer_pkg::STATUS_0, {31'h0, k < 2}, 32'h1);
        end
        wr(pwm_timer_pkg::SHARED_THREE, 32'h01);
        for (int k = 0; k < 2; k++) begin
            clr_lvl <= ~k[0];
            repeat (8) @(posedge clk);
            rd(pwm_timer_pkg::STATUS_0, {30'h0, k[0], 1'b0}, 32'h2);
        end
        // Partner clock rises once every four master cycles
        cnt_en <= 1'b1;
        wr(pwm_timer_pkg::SHARED_THREE, 32'h10);
        prog(8'h00, 8'h80, 1, 4, 2);
        wr(pwm_timer_pkg::CTRL_ONE_0, 32'h81);
        measure(0, hi, lo);
        check(32'(hi), 32'd16);
        check(32'(hi + lo), 32'd32);
        repeat (4) @(posedge clk);
        if (exp_q.size() != 0) fails++;
        final_report();
    end
endmodule // tb_top
